//--- shared/dlmd_pkg.sv
/*
 * dlmd_pkg: register map, field layouts, reset values, modes and timing
 * constants of the dual-loop mode and divider block.
 * Assumes a 100 MHz system clock and a 32-bit word-aligned register port.
 */
`default_nettype none
package dlmd_pkg;
	localparam int          CLK_NS    = 10;
	localparam int          LOS_NS    = 1000;
	localparam int          LOS_CYC   = LOS_NS / CLK_NS;
	localparam int          LOS_W     = 8;
	localparam int          ISYN_KHZ  = 3932160;
	localparam int          NCH       = 8;
	localparam logic [7:0]  A_MODE    = 8'h00;
	localparam logic [7:0]  A_CDIV    = 8'h04;
	localparam logic [7:0]  A_SDIV    = 8'h08;
	localparam logic [7:0]  A_SHDIV   = 8'h0C;
	localparam logic [7:0]  A_STAT    = 8'h10;
	localparam logic [7:0]  A_CHAN    = 8'h20;
	localparam logic [31:0] MODE_RST  = 32'h0000_0000;
	localparam logic [31:0] CDIV_RST  = 32'h0001_0001;
	localparam logic [31:0] SDIV_RST  = 32'h0001_0001;
	localparam logic [13:0] SHDIV_RST = 14'h0001;
	localparam logic [31:0] CHAN_RST  = 32'h0000_0001;
	localparam logic [2:0]  BASE_MAX  = 3'h5;
	localparam logic [3:0]  EXP_MAX   = 4'hC;
	localparam logic [26:0] RATIO_MAX = 27'h500_0000;

	typedef enum logic [1:0] {M_DUAL, M_SYNTH, M_CLEAN, M_FANOUT} dlmd_mode_t;

	typedef struct packed {
		logic [17:0] rsv;
		logic        synth_pd;
		logic        cleaner_pd;
		logic        manual_sel;
		logic        auto_sw;
		logic        pref_ref;
		logic [1:0]  prescale_sel;
		logic        ext_synth_osc;
		logic        ext_osc_halve_select;
		logic        synth_ref_doubler;
		logic        cleaner_feedback_route;
		logic [1:0]  timing_source_select;
		logic        cleaner_loop_bypass;
	} dlmd_mode_reg_t;

	typedef struct packed {
		logic        rsv1;
		logic [14:0] fb;
		logic        rsv0;
		logic [14:0] pre;
	} dlmd_cdiv_t;

	typedef struct packed {
		logic [5:0] rsv1;
		logic [9:0] fb;
		logic [8:0] rsv0;
		logic [6:0] pre;
	} dlmd_sdiv_t;

	typedef struct packed {
		logic [3:0] out1_dly;
		logic [3:0] out0_dly;
		logic [7:0] ch_dly;
		logic [1:0] out_pd;
		logic       ch_pd;
		logic [3:0] sysref_exp;
		logic       sysref_en;
		logic [3:0] div_exp;
		logic       rsv;
		logic [2:0] div_base;
	} dlmd_chan_reg_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} dlmd_bus_t;

	typedef struct packed {
		logic cl_ref;
		logic cl_fb;
		logic sy_ref;
		logic sy_fb;
	} dlmd_cmp_t;
endpackage
`default_nettype wire

//--- hdl/dlmd_div.sv
/*
 * dlmd_div: integer tick divider, one pulse per ratio input ticks.
 * Assumes ticks are single-cycle pulses on the system clock.
 */
`timescale 1ns/10ps
`default_nettype none
module dlmd_div
	import dlmd_pkg::*;
#(
	parameter int W = 15
) (
	// clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	// count control
	input  wire logic         i_restart,
	input  wire logic         i_tick,
	input  wire logic [W-1:0] i_ratio,
	// terminal count
	output logic              o_pulse
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic [W-1:0] ratio;
		logic         pulse;
	} dlmd_div_st_t;

	dlmd_div_st_t s_q, s_d;
	logic [W-1:0] eff;

	if (W < 2 || W > 16) begin : g_bad
		$error("dlmd_div: W out of range");
	end

	always_comb begin
		// ratio 0 acts as 1
		eff = (s_q.ratio == '0) ? W'(1) : s_q.ratio;
		s_d = s_q;
		s_d.pulse = 1'b0;
		if (i_restart) begin
			s_d.cnt = '0;
			s_d.ratio = i_ratio;
		end else if (i_tick) begin
			if (s_q.cnt >= eff - W'(1)) begin
				// new ratio only here or on restart: no runt period
				s_d.cnt = '0;
				s_d.ratio = i_ratio;
				s_d.pulse = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt + W'(1);
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_pulse = s_q.pulse;

	a_div_pulse_src: assert property (@(posedge i_clk) disable iff (i_rst)
		o_pulse |-> $past(i_tick) && !$past(i_restart))
		else $error("divider pulse without a tick");
	a_div_ratio_hold: assert property (@(posedge i_clk)
		disable iff (i_rst) $changed(s_q.ratio) |-> o_pulse || $past(i_restart))
		else $error("divider ratio changed mid-period");
	a_div_cnt_bound: assert property (@(posedge i_clk) disable iff (i_rst)
		s_q.cnt < eff)
		else $error("divider count beyond ratio");
endmodule
`default_nettype wire

//--- hdl/dlmd_chan.sv
/*
 * dlmd_chan: one output channel, clock or SYSREF divider with a channel
 * phase offset and a per-output tick delay.
 * Assumes all channels share one central tick and one restart.
 */
`timescale 1ns/10ps
`default_nettype none
module dlmd_chan
	import dlmd_pkg::*;
(
	// clock and reset
	input  wire logic           i_clk,
	input  wire logic           i_rst,
	// timing reference and channel configuration
	input  wire logic           i_restart,
	input  wire logic           i_tick,
	input  wire dlmd_chan_reg_t i_cfg,
	// outputs
	output logic [1:0]          o_out
);
	typedef struct packed {
		logic [26:0] cnt;
		logic [26:0] ratio;
		logic [15:0] hist;
		logic [1:0]  out;
	} dlmd_chan_st_t;

	dlmd_chan_st_t s_q, s_d;
	logic [2:0]  base;
	logic [3:0]  m;
	logic [3:0]  p;
	logic [26:0] rat;
	logic        term;
	logic        tk;

	always_comb begin
		// out-of-range fields clamp to the legal set
		base = (i_cfg.div_base == 3'h0 || i_cfg.div_base > BASE_MAX) ?
			3'h1 : i_cfg.div_base;
		m = (i_cfg.div_exp > EXP_MAX) ? EXP_MAX : i_cfg.div_exp;
		p = 4'h0;
		if (i_cfg.sysref_en) begin
			p = (i_cfg.sysref_exp == 4'h0) ? 4'h1 : i_cfg.sysref_exp;
			p = (p > EXP_MAX) ? EXP_MAX : p;
		end
		rat = 27'(base) << ({1'b0, m} + {1'b0, p});
		term = s_q.cnt >= s_q.ratio - 27'h1;
		s_d = s_q;
		if (i_restart || i_cfg.ch_pd) begin
			// channel offset preloads the count
			s_d.cnt = i_cfg.ch_pd ? 27'h0 : 27'(i_cfg.ch_dly);
			s_d.ratio = rat;
			s_d.hist = '0;
		end else if (i_tick) begin
			s_d.hist = {s_q.hist[14:0], term};
			if (term) begin
				s_d.cnt = '0;
				s_d.ratio = rat;
			end else begin
				s_d.cnt = s_q.cnt + 27'h1;
			end
		end
		// per-output delay taps the tick history
		// gated by the tick: a held tap would stretch the pulse
		tk = i_tick & ~i_restart & ~i_cfg.ch_pd;
		s_d.out[0] = tk & s_d.hist[i_cfg.out0_dly] & ~i_cfg.out_pd[0];
		s_d.out[1] = tk & s_d.hist[i_cfg.out1_dly] & ~i_cfg.out_pd[1];
		if (i_cfg.ch_pd) begin
			s_d.out = 2'h0;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s_q <= '{cnt: '0, ratio: 27'h1, hist: '0, out: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign o_out = s_q.out;

	a_chan_pd_quiet: assert property (@(posedge i_clk)
		disable iff (i_rst) i_cfg.ch_pd |=> o_out == 2'h0)
		else $error("powered-down channel drives an output");
	a_chan_ratio_max: assert property (@(posedge i_clk)
		disable iff (i_rst) s_q.ratio <= RATIO_MAX && s_q.ratio != 27'h0)
		else $error("channel ratio outside its range");
endmodule
`default_nettype wire

//--- hdl/dlmd_top.sv
/*
 * dlmd_top: mode decode, reference selection and the divider chain of a
 * two-loop clock generator; loop and oscillator edges arrive as pins and
 * the dividers count their edges, or each cycle on the internal synth oscillator, as ticks on the system clock.
 * Assumes pin edges are slower than half the system clock and that
 * software keeps analog frequency limits.
 */
// Operation
// - bypass bit and source field pick dual, synth, cleaner or fanout
// - dual mode with route set: feedback through cleaner and shared dividers
// - input prescaler divides by 1, 2, 4 or 8 only
// - cleaner pre-divider is 15 bits, ratios 1 to 32767
// - cleaner feedback divider is 15 bits, ratios 1 to 32767
// - shared feedback divider is 14 bits, ratios 1 to 16383
// - synth pre-divider is 7 bits, ratios 1 to 127
// - doubler multiplies the synth reference by 1 or 2
// - synth feedback divider is 10 bits, up to 1023
// - clock divider is base 1 to 5 times 2 to the 0..12
// - SYSREF adds a further 2 to the 1..12, up to 83886080
// - internal synth oscillator fixed; external rates chosen by designer
// - synth output is the central reference, cleaner output in cleaner-only mode, synth pre-divider output in fanout
// - eight channels, each clock or SYSREF
// - SYSREF stays synchronous to clocks from the same reference
// - each channel and each output has a programmable delay
// - two references, auto switch by priority, with holdover
// - outputs, channels and unused blocks can be powered down
`timescale 1ns/10ps
`default_nettype none
module dlmd_top
	import dlmd_pkg::*;
#(
	parameter int LOS_CYCLES = LOS_CYC
) (
	// clock and reset
	input  wire logic          i_clk,
	input  wire logic          i_rst,
	// register port
	input  wire dlmd_bus_t     i_bus,
	output logic [31:0]        o_rdata,
	// reference and oscillator pins
	input  wire logic [1:0]    i_ref_pin,
	input  wire logic          i_cleaner_osc_pin,
	input  wire logic          i_synth_osc_pin,
	// channel outputs
	output logic [2*NCH-1:0]   o_chan_out,
	// loop compare pulses and status
	output dlmd_cmp_t          o_cmp,
	output dlmd_mode_t         o_mode,
	output logic               o_ref_sel,
	output logic               o_holdover
);
	typedef struct packed {
		logic [3:0]                  sy1;
		logic [3:0]                  sy2;
		logic [3:0]                  prv;
		logic                        half;
		logic                        srtk;
		dlmd_mode_reg_t              mr;
		dlmd_cdiv_t                  cdiv;
		dlmd_sdiv_t                  sdiv;
		logic [13:0]                 shdiv;
		dlmd_chan_reg_t [NCH-1:0]    ch;
		logic [1:0][LOS_W-1:0]       los;
		logic                        sel;
		logic                        hold;
		dlmd_mode_t                  mode;
		logic                        restart;
		logic [2*NCH-1:0]            out;
		dlmd_cmp_t                   cmp;
		logic [31:0]                 rdata;
	} dlmd_st_t;

	dlmd_st_t         s_q, s_d;
	dlmd_mode_t       md;
	logic [3:0]       rise;
	logic [1:0]       act;
	logic [3:0]       pre_ratio;
	logic             ref_tk;
	logic             pre_tk;
	logic             cp_tk;
	logic             sh_in;
	logic             sh_tk;
	logic             cf_in;
	logic             cf_tk;
	logic             osc_tk;
	logic             sr_src;
	logic             sr_tk;
	logic             sp_tk;
	logic             sf_tk;
	logic             cen_tk;
	logic             fb_both;
	logic [2*NCH-1:0] chout;

	if (LOS_CYCLES < 2 || LOS_CYCLES >= 2**LOS_W) begin : g_bad
		$error("dlmd_top: LOS_CYCLES out of range");
	end

	// edges of the synchronised pins: ref0, ref1, cleaner, synth osc
	assign rise = s_q.sy2 & ~s_q.prv;
	assign act[0] = s_q.los[0] < LOS_W'(LOS_CYCLES);
	assign act[1] = s_q.los[1] < LOS_W'(LOS_CYCLES);

	always_comb begin
		// decode straight from the register bits
		unique case (s_q.mr.timing_source_select)
			2'b10: md = M_CLEAN;
			2'b11: md = M_FANOUT;
			default: md = s_q.mr.cleaner_loop_bypass ? M_SYNTH : M_DUAL;
		endcase
	end

	// reference path
	assign ref_tk = rise[{1'b0, s_q.sel}] & ~s_q.hold;
	assign pre_ratio = 4'h1 << s_q.mr.prescale_sel;

	dlmd_div #(
		.W (4)
	) u_presc (
		.i_clk     (i_clk),
		.i_rst     (i_rst),
		.i_restart (1'b0),
		.i_tick    (ref_tk),
		.i_ratio   (pre_ratio),
		.o_pulse   (pre_tk)
	);

	// cleaner loop, held in restart while powered down
	dlmd_div #(
		.W (15)
	) u_cl_pre (
		.i_clk     (i_clk),
		.i_rst     (i_rst),
		.i_restart (s_q.mr.cleaner_pd),
		.i_tick    (pre_tk),
		.i_ratio   (s_q.cdiv.pre),
		.o_pulse   (cp_tk)
	);

	// in dual mode the route bit closes the cleaner loop through both dividers
	assign fb_both = s_q.mr.cleaner_feedback_route && md == M_DUAL;
	assign sh_in = fb_both & osc_tk;
	assign cf_in = fb_both ? sh_tk : rise[2];

	dlmd_div #(
		.W (14)
	) u_sh_fb (
		.i_clk     (i_clk),
		.i_rst     (i_rst),
		.i_restart (s_q.mr.cleaner_pd),
		.i_tick    (sh_in),
		.i_ratio   (s_q.shdiv),
		.o_pulse   (sh_tk)
	);

	dlmd_div #(
		.W (15)
	) u_cl_fb (
		.i_clk     (i_clk),
		.i_rst     (i_rst),
		.i_restart (s_q.mr.cleaner_pd),
		.i_tick    (cf_in),
		.i_ratio   (s_q.cdiv.fb),
		.o_pulse   (cf_tk)
	);

	// internal oscillator ticks every cycle; external one may be halved
	always_comb begin
		osc_tk = 1'b1;
		if (s_q.mr.ext_synth_osc) begin
			osc_tk = s_q.mr.ext_osc_halve_select ?
				rise[3] & s_q.half : rise[3];
		end
	end

	// doubler: a tick counts on both of its edges
	assign sr_src = (md == M_DUAL) ? rise[2] : pre_tk;
	assign sr_tk = sr_src | (s_q.mr.synth_ref_doubler & s_q.srtk);

	dlmd_div #(
		.W (7)
	) u_sy_pre (
		.i_clk     (i_clk),
		.i_rst     (i_rst),
		.i_restart (s_q.mr.synth_pd),
		.i_tick    (sr_tk),
		.i_ratio   (s_q.sdiv.pre),
		.o_pulse   (sp_tk)
	);

	dlmd_div #(
		.W (10)
	) u_sy_fb (
		.i_clk     (i_clk),
		.i_rst     (i_rst),
		.i_restart (s_q.mr.synth_pd),
		.i_tick    (osc_tk),
		.i_ratio   (s_q.sdiv.fb),
		.o_pulse   (sf_tk)
	);

	// central timing reference
	always_comb begin
		unique case (md)
			M_DUAL, M_SYNTH: cen_tk = osc_tk;
			M_CLEAN: cen_tk = rise[2];
			M_FANOUT: cen_tk = sp_tk;
		endcase
	end

	// one tick and one restart for all channels
	for (genvar g = 0; g < NCH; g++) begin : g_ch
		dlmd_chan u_ch (
			.i_clk     (i_clk),
			.i_rst     (i_rst),
			.i_restart (s_q.restart),
			.i_tick    (cen_tk),
			.i_cfg     (s_q.ch[g]),
			.o_out     (chout[2*g+1:2*g])
		);
	end

	always_comb begin
		s_d = s_q;
		s_d.sy1 = {i_synth_osc_pin, i_cleaner_osc_pin, i_ref_pin};
		s_d.sy2 = s_q.sy1;
		s_d.prv = s_q.sy2;
		s_d.half = s_q.half ^ rise[3];
		s_d.srtk = sr_src;
		// activity monitors saturate at the loss limit
		for (int i = 0; i < 2; i++) begin
			if (rise[i]) begin
				s_d.los[i] = '0;
			end else if (act[i]) begin
				s_d.los[i] = s_q.los[i] + LOS_W'(1);
			end
		end
		// manual choice in fanout or with auto switch off, priority with holdover otherwise
		if (!s_q.mr.auto_sw || md == M_FANOUT) begin
			s_d.sel = s_q.mr.manual_sel;
			s_d.hold = 1'b0;
		end else if (act[s_q.mr.pref_ref]) begin
			s_d.sel = s_q.mr.pref_ref;
			s_d.hold = 1'b0;
		end else if (act[~s_q.mr.pref_ref]) begin
			s_d.sel = ~s_q.mr.pref_ref;
			s_d.hold = 1'b0;
		end else begin
			s_d.hold = 1'b1;
		end
		s_d.mode = md;
		s_d.restart = md != s_q.mode;
		s_d.out = chout;
		s_d.cmp = '{cl_ref: cp_tk, cl_fb: cf_tk, sy_ref: sp_tk, sy_fb: sf_tk};
		// register writes; reserved bits forced to zero
		if (i_bus.wr) begin
			unique case (i_bus.addr)
				A_MODE: begin
					s_d.mr = i_bus.wdata;
					s_d.mr.rsv = '0;
				end
				A_CDIV: begin
					s_d.cdiv = i_bus.wdata;
					s_d.cdiv.rsv0 = 1'b0;
					s_d.cdiv.rsv1 = 1'b0;
				end
				A_SDIV: begin
					s_d.sdiv = i_bus.wdata;
					s_d.sdiv.rsv0 = '0;
					s_d.sdiv.rsv1 = '0;
				end
				A_SHDIV: s_d.shdiv = i_bus.wdata[13:0];
				default: begin
					if (i_bus.addr[7:5] == A_CHAN[7:5]) begin
						s_d.ch[i_bus.addr[4:2]] = i_bus.wdata;
						s_d.ch[i_bus.addr[4:2]].rsv = 1'b0;
					end
				end
			endcase
		end
		// read data stand for the one cycle after the strobe
		s_d.rdata = '0;
		if (i_bus.rd) begin
			unique case (i_bus.addr)
				A_MODE: s_d.rdata = s_q.mr;
				A_CDIV: s_d.rdata = s_q.cdiv;
				A_SDIV: s_d.rdata = s_q.sdiv;
				A_SHDIV: s_d.rdata = {18'h0, s_q.shdiv};
				A_STAT: s_d.rdata = {26'h0, s_q.hold, s_q.sel, act, s_q.mode};
				default: begin
					if (i_bus.addr[7:5] == A_CHAN[7:5]) begin
						s_d.rdata = s_q.ch[i_bus.addr[4:2]];
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s_q <= '0;
			s_q.mr <= MODE_RST;
			s_q.cdiv <= CDIV_RST;
			s_q.sdiv <= SDIV_RST;
			s_q.shdiv <= SHDIV_RST;
			s_q.ch <= {NCH{CHAN_RST}};
			s_q.mode <= M_DUAL;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_rdata = s_q.rdata;
	assign o_chan_out = s_q.out;
	assign o_cmp = s_q.cmp;
	assign o_mode = s_q.mode;
	assign o_ref_sel = s_q.sel;
	assign o_holdover = s_q.hold;

	a_mode_clean: assert property (@(posedge i_clk) disable iff (i_rst)
		s_q.mr.timing_source_select == 2'b10 |=> o_mode == M_CLEAN)
		else $error("source 10 did not give cleaner-only mode");
	a_mode_loops: assert property (@(posedge i_clk) disable iff (i_rst)
		!s_q.mr.timing_source_select[1] |=>
		o_mode == ($past(s_q.mr.cleaner_loop_bypass) ? M_SYNTH : M_DUAL))
		else $error("bypass bit did not steer the loop mode");
	a_fb_route: assert property (@(posedge i_clk) disable iff (i_rst)
		fb_both |-> cf_in == sh_tk && sh_in == osc_tk)
		else $error("cleaner feedback not through both dividers");
	a_presc_ratio: assert property (@(posedge i_clk) disable iff (i_rst)
		$onehot(pre_ratio) && pre_ratio <= 4'h8)
		else $error("prescaler ratio outside 1, 2, 4, 8");
	a_dbl_second: assert property (@(posedge i_clk) disable iff (i_rst)
		sr_src ##1 s_q.mr.synth_ref_doubler |-> sr_tk)
		else $error("doubler missed its second tick");
	a_central_src: assert property (@(posedge i_clk) disable iff (i_rst)
		md == M_CLEAN |-> cen_tk == rise[2])
		else $error("bypassed synth loop not replaced by cleaner");
	a_mode_restart: assert property (@(posedge i_clk) disable iff (i_rst)
		md != s_q.mode |=> s_q.restart ##1 !s_q.restart || $changed(md))
		else $error("mode change did not restart channels once");
	a_hold_no_ref: assert property (@(posedge i_clk) disable iff (i_rst)
		s_q.hold |-> !ref_tk && !act[0] || s_q.hold && !ref_tk)
		else $error("reference tick passed during holdover");
	a_read_idle: assert property (@(posedge i_clk) disable iff (i_rst)
		!i_bus.rd |=> o_rdata == 32'h0000_0000)
		else $error("read data outside the read answer cycle");
endmodule
`default_nettype wire

//--- sim/tb_top.sv
/*
 * tb_top: self-checking bench for dlmd_top; register reads are noted in a
 * queue and compared by a monitor, divider pulse periods are measured.
 * Assumes the design's own assertions and a 100 MHz clock.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import dlmd_pkg::*;
;
	typedef struct {
		string       name;
		logic [31:0] exp;
		logic [31:0] mask;
	} dlmd_note_t;

	logic              i_clk;
	logic              i_rst;
	dlmd_bus_t         i_bus = '0;
	logic [31:0]       o_rdata;
	logic [1:0]        i_ref_pin = 2'h0;
	logic              i_cleaner_osc_pin = 1'b0;
	logic              i_synth_osc_pin = 1'b0;
	logic [2*NCH-1:0]  o_chan_out;
	dlmd_cmp_t         o_cmp;
	dlmd_mode_t        o_mode;
	logic              o_ref_sel;
	logic              o_holdover;
	logic [19:0]       watch;
	logic              rd_q = 1'b0;
	logic [1:0]        pin_cnt = 2'h0;
	logic              pins_on = 1'b1;
	int                n_mismatch = 0;
	int                comparisons = 0;
	dlmd_note_t        notes[$];

	dlmd_top #(.LOS_CYCLES(16)) dut (
		.i_clk             (i_clk),
		.i_rst             (i_rst),
		.i_bus             (i_bus),
		.o_rdata           (o_rdata),
		.i_ref_pin         (i_ref_pin),
		.i_cleaner_osc_pin (i_cleaner_osc_pin),
		.i_synth_osc_pin   (i_synth_osc_pin),
		.o_chan_out        (o_chan_out),
		.o_cmp             (o_cmp),
		.o_mode            (o_mode),
		.o_ref_sel         (o_ref_sel),
		.o_holdover        (o_holdover)
	);

	// cl_ref 19, cl_fb 18, sy_ref 17, sy_fb 16, channel ch out0 at 2*ch
	assign watch = {o_cmp, o_chan_out};

	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	// pin edges every 6 cycles, well over the 2-cycle minimum spacing
	always @(posedge i_clk) begin
		pin_cnt <= (pin_cnt == 2'h2) ? 2'h0 : pin_cnt + 2'h1;
		if (pins_on && pin_cnt == 2'h2) begin
			i_ref_pin <= ~i_ref_pin;
			i_cleaner_osc_pin <= ~i_cleaner_osc_pin;
			i_synth_osc_pin <= ~i_synth_osc_pin;
		end
	end

	task automatic report_and_stop();
		$display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// read data stands only in the cycle after the strobe
	always @(posedge i_clk) rd_q <= i_bus.rd;
	always @(negedge i_clk) begin
		dlmd_note_t n;
		if (rd_q === 1'b1 && notes.size() > 0) begin
			n = notes.pop_front();
			check(n.name, o_rdata & n.mask, n.exp);
		end
	end

	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge i_clk);
		i_bus <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge i_clk);
		i_bus <= '0;
	endtask

	task automatic rd(input string nm, input logic [7:0] a,
		input logic [31:0] e, input logic [31:0] m);
		notes.push_back('{nm, e & m, m});
		bus(1'b0, a, 32'h0000_0000);
	endtask

	// skip two pulses: pipeline leftovers and the period that loads a
	// new ratio, then time one full gap
	task automatic period(input int idx, input int exp, input string nm);
		int t;
		int n;
		int t0;
		t = 0;
		n = 0;
		t0 = 0;
		while (n < 4 && t < 6000) begin
			@(negedge i_clk);
			t++;
			if (watch[idx] === 1'b1) begin
				n++;
				if (n == 3)
					t0 = t;
			end
		end
		if (n < 4) begin
			check(nm, 32'(n), 32'h0000_0004);
			report_and_stop();
		end else begin
			check(nm, 32'(t - t0), 32'(exp));
		end
	endtask

	task automatic silent(input int idx, input string nm);
		int c;
		c = 0;
		// let pulses already in the output pipeline drain
		repeat (3) @(negedge i_clk);
		repeat (60) begin
			@(negedge i_clk);
			if (watch[idx] !== 1'b0)
				c++;
		end
		check(nm, 32'(c), 32'h0000_0000);
	endtask

	initial begin
		logic [31:0] r;
		int          b;
		int          m;
		i_rst = 1'b1;
		void'($urandom(84));
		repeat (8) @(posedge i_clk);
		i_rst <= 1'b0;
		rd("mode", A_MODE, MODE_RST, 32'hFFFF_FFFF);
		rd("cdiv", A_CDIV, CDIV_RST, 32'hFFFF_FFFF);
		rd("sdiv", A_SDIV, SDIV_RST, 32'hFFFF_FFFF);
		rd("shdiv", A_SHDIV, 32'(SHDIV_RST), 32'hFFFF_FFFF);
		for (int ch = 0; ch < NCH; ch++)
			rd("chan", A_CHAN + 8'(4 * ch), CHAN_RST, 32'hFFFF_FFFF);
		// field widths: reserved bits must read back as zero
		bus(1'b1, A_CDIV, 32'hFFFF_FFFF);
		rd("cdiv", A_CDIV, 32'h7FFF_7FFF, 32'hFFFF_FFFF);
		bus(1'b1, A_SDIV, 32'hFFFF_FFFF);
		rd("sdiv", A_SDIV, 32'h03FF_007F, 32'hFFFF_FFFF);
		r = $urandom();
		bus(1'b1, A_SHDIV, r);
		rd("shdiv", A_SHDIV, r & 32'h0000_3FFF, 32'hFFFF_FFFF);
		bus(1'b1, 8'h14, 32'hFFFF_FFFF);
		rd("unmapped", 8'h14, 32'h0000_0000, 32'hFFFF_FFFF);
		// every bypass and source combination
		for (int i = 0; i < 8; i++) begin
			b = i & 1;
			m = i >> 1;
			r = (m == 2) ? 2 : (m == 3) ? 3 : b;
			bus(1'b1, A_MODE, 32'(i));
			rd("status mode", A_STAT, r, 32'h0000_0003);
			check("o_mode", 32'(o_mode), r);
		end
		// synth-only on the internal oscillator: one tick per cycle
		bus(1'b1, A_MODE, 32'h0000_0001);
		for (int ch = 0; ch < NCH; ch++) begin
			bus(1'b1, A_CHAN + 8'(4 * ch), 32'((ch % 5) + 1 + ((ch / 5) << 4)));
			period(2 * ch, ((ch % 5) + 1) << (ch / 5),
				"chan clk");
		end
		b = $urandom_range(5, 1);
		m = $urandom_range(2, 0);
		bus(1'b1, A_CHAN, 32'(b + (m << 4)));
		period(0, b << m, "chan rand");
		bus(1'b1, A_CHAN + 8'h08, 32'h0000_0303);
		period(4, 6, "sysref p1");
		bus(1'b1, A_CHAN + 8'h08, 32'h0000_0511);
		period(4, 8, "sysref p2");
		period(5, 8, "sysref out1");
		bus(1'b1, A_CHAN + 8'h04, 32'h0000_2001);
		silent(2, "chan pd");
		bus(1'b1, A_CHAN + 8'h0C, 32'h0000_4002);
		silent(6, "out pd");
		period(7, 2, "out live");
		// synth loop dividers and doubler
		bus(1'b1, A_SDIV, 32'h03FF_0001);
		period(16, 1023, "sy_fb max");
		bus(1'b1, A_SDIV, 32'h0008_0002);
		period(16, 8, "sy_fb");
		period(17, 12, "sy_ref");
		bus(1'b1, A_MODE, 32'h0000_0011);
		period(17, 6, "sy_ref dbl");
		// cleaner-only: central reference from the cleaner oscillator
		bus(1'b1, A_SHDIV, 32'h0000_0005);
		bus(1'b1, A_CDIV, 32'h0003_0002);
		bus(1'b1, A_CHAN, 32'h0000_0001);
		// old all-ones ratios would need thousands of ticks to run out
		bus(1'b1, A_MODE, 32'h0000_1004);
		for (int s = 0; s < 4; s++) begin
			bus(1'b1, A_MODE, 32'h0000_0004 | 32'(s << 7));
			period(19, 12 << s, "cl_ref");
		end
		period(18, 18, "cl_fb");
		period(0, 6, "chan clean");
		// dual mode with feedback through both dividers
		bus(1'b1, A_MODE, 32'h0000_0008);
		period(18, 15, "cl_fb dual");
		// external synth oscillator, plain then halved
		bus(1'b1, A_MODE, 32'h0000_0041);
		period(16, 48, "sy_fb ext");
		bus(1'b1, A_MODE, 32'h0000_0061);
		period(16, 96, "sy_fb ext half");
		// auto switch takes the preferred input, then holds over
		bus(1'b1, A_MODE, 32'h0000_0601);
		rd("status auto", A_STAT, 32'h0000_001D, 32'h0000_003F);
		check("o_ref_sel", 32'(o_ref_sel), 32'h0000_0001);
		pins_on <= 1'b0;
		repeat (30) @(posedge i_clk);
		rd("status hold", A_STAT, 32'h0000_0031, 32'h0000_003F);
		check("o_holdover", 32'(o_holdover), 32'h0000_0001);
		repeat (2) @(posedge i_clk);
		report_and_stop();
	end
endmodule
`default_nettype wire
